/* File: core/pdl_pkg.sv */
`default_nettype none

package pdl_pkg;

    // data formats; integer formats carry no fraction bits
    typedef enum logic [1:0] {
        FMT_SINT,
        FMT_UINT,
        FMT_SFRAC
    } pdl_fmt_t;

    localparam pdl_fmt_t FMT       = FMT_SFRAC;
    localparam int       INT_BITS  = 12;
    localparam int       FRAC_CFG  = 4;
    localparam int       FRAC_BITS = (FMT == FMT_SFRAC) ? FRAC_CFG : 0;
    localparam int       WORD_W    = INT_BITS + FRAC_BITS;
    localparam int       NSTAGES   = 4;

    // phase selection pattern, up to eight phases
    localparam int PH_MAX = 8;
    localparam int PH_LW  = 3;

    typedef logic [WORD_W-1:0] pdl_word_t;

    typedef struct packed {
        logic use_rstval;
        logic use_sclr;
        logic use_ena;
    } pdl_ctrl_t;

    typedef struct packed {
        logic [PH_LW-1:0]  len_m1;
        logic [PH_MAX-1:0] pattern;
    } pdl_phase_t;

    // register port
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 32;
    localparam int CTRL_W  = 3;
    localparam int PHASE_W = PH_LW + PH_MAX;

    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PHASE  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_RSTVAL = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hc;

    // status fields
    localparam int ST_VLD_LSB  = 0;
    localparam int ST_FULL_BIT = 8;
    localparam int ST_SIGN_BIT = 9;
    localparam int ST_PH_LSB   = 12;

    // values after reset
    localparam pdl_ctrl_t  CTRL_RST   = 3'h2;
    localparam pdl_phase_t PHASE_RST  = 11'h001;
    localparam pdl_word_t  RSTVAL_DEF = pdl_word_t'(32'h0000_0000);
    localparam pdl_word_t  STAGE_RST  = CTRL_RST.use_rstval ? RSTVAL_DEF : pdl_word_t'(32'h0);

endpackage

`default_nettype wire

/* File: core/pdl_buf2.sv */
`default_nettype none

module pdl_buf2 (
    input  wire logic              clk,        // system clock
    input  wire logic              rst_n,      // synchronised reset, active low
    input  wire logic              flush,      // drop both entries
    input  wire pdl_pkg::pdl_word_t flush_val, // value shown on the output after flush
    input  wire logic              in_valid,   // word offered
    input  wire pdl_pkg::pdl_word_t in_data,   // offered word
    output var  logic              in_ready,   // second entry free
    output var  logic              out_valid,  // head entry holds a word
    output var  pdl_pkg::pdl_word_t out_data,  // head entry
    input  wire logic              out_ready   // receiver takes the head
);
    import pdl_pkg::*;

    pdl_word_t ent1;
    logic      push;
    logic      pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // head is always a flop, so the output never passes a mux
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
            out_data  <= STAGE_RST;
            ent1      <= STAGE_RST;
        end else if (flush) begin
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
            out_data  <= flush_val;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (!out_valid) begin
                        out_data  <= in_data;
                        out_valid <= 1'b1;
                    end else begin
                        ent1     <= in_data;
                        in_ready <= 1'b0;
                    end
                end
                2'b01: begin
                    if (!in_ready) begin
                        out_data <= ent1;
                        in_ready <= 1'b1;
                    end else begin
                        out_valid <= 1'b0;
                    end
                end
                2'b11: begin
                    // push needs a free second entry, so the head simply refills
                    out_data <= in_data;
                end
                default: begin
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: core/pdl_delay_line.sv */
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none

module pdl_delay_line (
    input  wire logic                          clk,       // 100 MHz system clock
    input  wire logic                          resetn,    // asynchronous reset, active low
    input  wire logic [pdl_pkg::ADDR_W-1:0]    addr,      // register byte address
    input  wire logic [pdl_pkg::DATA_W-1:0]    wdata,     // register write data
    input  wire logic                          wr,        // register write strobe
    input  wire logic                          rd,        // register read strobe
    output var  logic [pdl_pkg::DATA_W-1:0]    rdata,     // read data, cycle after rd
    input  wire pdl_pkg::pdl_word_t            in_data,   // input word
    input  wire logic                          in_valid,  // input word is real
    output var  logic                          in_ready,  // output buffer has room
    input  wire logic                          ena,       // clock enable
    input  wire logic                          sclr,      // synchronous clear
    output var  pdl_pkg::pdl_word_t            out_data,  // delayed word
    output var  logic                          out_valid, // delayed word is real
    input  wire logic                          out_ready  // receiver takes the word
);
    import pdl_pkg::*;

    localparam int LAST = NSTAGES - 1;

    logic             rst_meta;
    logic             rst_q;
    pdl_ctrl_t        ctrl;
    pdl_phase_t       phase;
    pdl_word_t        rstval;
    logic [PH_LW-1:0] ph;
    pdl_word_t        stage   [NSTAGES];
    pdl_word_t        stage_d [NSTAGES];
    logic             vld     [NSTAGES];
    logic             vld_d   [NSTAGES];
    logic             hit;
    logic             ena_ok;
    logic             clr;
    logic             step;
    pdl_word_t        clr_val;
    logic [DATA_W-1:0] status_word;

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_q    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_q    <= rst_meta;
        end
    end

    // gating terms
    assign hit     = phase.pattern[phase.len_m1 - ph];
    assign ena_ok  = !ctrl.use_ena || ena;
    assign clr     = ctrl.use_sclr && sclr;
    assign clr_val = ctrl.use_rstval ? rstval : pdl_word_t'(32'h0);
    // clear is folded into step, so a clearing edge never also shifts
    // a full buffer only stalls when the last stage holds a real word
    assign step    = hit && ena_ok && (in_ready || !vld[LAST]) && !clr;

    // phase counter; first pattern character is phase 0
    // it ignores enable: phases follow the clock, not the data
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            ph <= '0;
        end else if (clr || (wr && addr == OFF_PHASE)) begin
            ph <= '0;
        end else if (ph == phase.len_m1) begin
            ph <= '0;
        end else begin
            ph <= PH_LW'(ph + 3'h1);
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            ctrl   <= CTRL_RST;
            phase  <= PHASE_RST;
            rstval <= RSTVAL_DEF;
        end else if (wr) begin
            case (addr)
                OFF_CTRL:   ctrl   <= pdl_ctrl_t'(wdata[CTRL_W-1:0]);
                OFF_PHASE:  phase  <= pdl_phase_t'(wdata[PHASE_W-1:0]);
                OFF_RSTVAL: rstval <= wdata[WORD_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        status_word = '0;
        for (int i = 0; i < NSTAGES; i++) begin
            status_word[ST_VLD_LSB + i] = vld[i];
        end
        status_word[ST_FULL_BIT] = !in_ready;
        // unsigned words have no sign to report
        status_word[ST_SIGN_BIT] = (FMT != FMT_UINT) && out_data[WORD_W-1];
        status_word[ST_PH_LSB +: PH_LW] = ph;
    end

    // read data lives for exactly one cycle
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                OFF_CTRL:   rdata <= DATA_W'(ctrl);
                OFF_PHASE:  rdata <= DATA_W'(phase);
                OFF_RSTVAL: rdata <= DATA_W'(rstval);
                OFF_STATUS: rdata <= status_word;
                default:    rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // pipeline stages
    genvar k;
    generate
        for (k = 0; k < NSTAGES; k++) begin : g_stage
            if (k == 0) begin : g_head
                assign stage_d[k] = in_data;
                assign vld_d[k]   = in_valid;
            end else begin : g_tail
                assign stage_d[k] = stage[k-1];
                assign vld_d[k]   = vld[k-1];
            end

            always_ff @(posedge clk or negedge rst_q) begin
                if (!rst_q) begin
                    stage[k] <= STAGE_RST;
                    vld[k]   <= 1'b0;
                end else if (clr) begin
                    stage[k] <= clr_val;
                    vld[k]   <= 1'b0;
                end else if (step) begin
                    stage[k] <= stage_d[k];
                    vld[k]   <= vld_d[k];
                end
            end
        end
    endgenerate

    // two-entry buffer keeps words when the receiver stalls
    // costs one register of latency after the last stage
    pdl_buf2 u_buf (
        .clk       (clk),
        .rst_n     (rst_q),
        .flush     (clr),
        .flush_val (clr_val),
        .in_valid  (step && vld[LAST]),
        .in_data   (stage[LAST]),
        .in_ready  (in_ready),
        .out_valid (out_valid),
        .out_data  (out_data),
        .out_ready (out_ready)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_q);

    a_first_stage: assert property (step |=> stage[0] == $past(in_data))
        else $error("first stage did not take the input word");
    a_chain_shift: assert property (step |=> stage[LAST] == $past(stage_d[LAST]))
        else $error("last stage did not shift");
    a_word_intact: assert property ((step && vld[LAST] && !out_valid)
        |=> out_valid && out_data == $past(stage[LAST]))
        else $error("output word differs from last stage");
    a_single_one: assert property ((phase == PHASE_RST && ena_ok && in_ready && !clr)
        |-> step)
        else $error("pattern 1 failed to enable");
    a_alt_phase: assert property ((phase.len_m1 == 3'h1 && phase.pattern[1:0] == 2'h2
        && step && !(wr && addr == OFF_PHASE)) |=> !step)
        else $error("pattern 10 stepped twice in a row");
    a_second_phase: assert property ((phase.len_m1 == 3'h3
        && phase.pattern[3:0] == 4'h4 && step) |-> ph == 3'h1)
        else $error("pattern 0100 stepped outside phase two");
    a_ena_hold: assert property ((ctrl.use_ena && !ena && !clr)
        |=> $stable(stage[0]) && $stable(vld[LAST]))
        else $error("stages moved with enable low");
    a_sync_clear: assert property (clr |=> stage[0] == $past(clr_val)
        && stage[LAST] == $past(clr_val) && !vld[LAST])
        else $error("clear did not load the stages");
    a_rst_const: assert property ($rose(rst_q)
        |-> stage[0] == STAGE_RST && stage[LAST] == STAGE_RST)
        else $error("stages left reset with wrong value");
    a_sign_bit: assert property ((rd && addr == OFF_STATUS)
        |=> rdata[ST_SIGN_BIT] == ((FMT != FMT_UINT) && $past(out_data[WORD_W-1])))
        else $error("status sign bit wrong");
    a_out_clear: assert property (clr |=> !out_valid && out_data == $past(clr_val))
        else $error("clear did not reach the output");
    a_clear_wins: assert property ((clr && hit && ena_ok)
        |=> stage[0] == $past(clr_val) && !vld[0])
        else $error("clear lost against enable or phase");

    // flow: the stages shift only on step, and a stall loses nothing
    a_vld_first: assert property (step |=> vld[0] == $past(in_valid))
        else $error("first valid bit did not follow the input");
    a_mid_shift: assert property (step |=> stage[1] == $past(stage[0]))
        else $error("second stage did not shift");
    a_vld_shift: assert property (step |=> vld[LAST] == $past(vld_d[LAST]))
        else $error("last valid bit did not shift");
    a_no_loss: assert property ((vld[LAST] && !in_ready) |-> !step)
        else $error("pipeline stepped into a full buffer");
    a_stall_hold: assert property ((vld[LAST] && !in_ready && !clr)
        |=> vld[LAST] && $stable(stage[LAST]))
        else $error("stalled word moved or vanished");
    a_head_hold: assert property ((out_valid && !out_ready && !clr)
        |=> out_valid && $stable(out_data))
        else $error("unaccepted output word changed");
    a_full_valid: assert property (!in_ready |-> out_valid)
        else $error("buffer full without a head word");
    a_full_drain: assert property ((!in_ready && out_ready && !clr)
        |=> in_ready && out_valid)
        else $error("second entry did not move to the head");
    a_push_last: assert property ((step && vld[LAST] && out_valid && !out_ready)
        |=> !in_ready)
        else $error("second entry not marked full");

    // phase counter restarts on a pattern write or a clear, wraps at the length
    a_ph_restart: assert property (((wr && addr == OFF_PHASE) || clr) |=> ph == '0)
        else $error("phase counter did not restart");
    a_ph_wrap: assert property ((!(wr && addr == OFF_PHASE) && !clr
        && ph == phase.len_m1) |=> ph == '0)
        else $error("phase counter did not wrap");
    a_ph_count: assert property ((!(wr && addr == OFF_PHASE) && !clr
        && ph != phase.len_m1) |=> ph == PH_LW'($past(ph) + 3'h1))
        else $error("phase counter did not advance");
    a_ph_range: assert property (ph <= phase.len_m1)
        else $error("phase counter beyond pattern length");
    a_phase_write: assert property ((wr && addr == OFF_PHASE)
        |=> phase == $past(wdata[PHASE_W-1:0]))
        else $error("phase pattern write lost");
    a_off_phase: assert property ((!hit && !clr)
        |=> $stable(stage[0]) && $stable(vld[0]))
        else $error("word taken on a disabled phase");

    // enable, clear and reset value
    a_ena_needed: assert property ((ctrl.use_ena && step) |-> ena)
        else $error("stepped with enable low");
    a_ena_free: assert property ((!ctrl.use_ena && hit && in_ready && !clr) |-> step)
        else $error("unused enable still gated the stages");
    a_ctrl_write: assert property ((wr && addr == OFF_CTRL)
        |=> ctrl == $past(wdata[CTRL_W-1:0]))
        else $error("control write lost");
    a_clr_ignored: assert property ((sclr && !ctrl.use_sclr && step)
        |=> stage[0] == $past(in_data) && vld[0] == $past(in_valid))
        else $error("clear obeyed while not in use");
    a_rstval_write: assert property ((wr && addr == OFF_RSTVAL)
        |=> rstval == $past(wdata[WORD_W-1:0]))
        else $error("reset value write lost");
    a_rstval_clear: assert property ((clr && ctrl.use_rstval)
        |=> out_data == $past(rstval) && stage[LAST-1] == $past(rstval))
        else $error("clear did not load the reset value");
    a_rst_out: assert property ($rose(rst_q)
        |-> out_data == STAGE_RST && !out_valid)
        else $error("output left reset with wrong value");
    a_zero_clear: assert property ((clr && !ctrl.use_rstval)
        |=> out_data == '0 && stage[0] == '0)
        else $error("clear without reset value left a non-zero word");
    a_clr_ready: assert property (clr |=> in_ready && !vld[LAST-1])
        else $error("clear left the buffer full");
    a_clear_first: assert property (clr |-> !step)
        else $error("stepped during a clear");

    // register read back
    a_status_full: assert property ((rd && addr == OFF_STATUS)
        |=> rdata[ST_FULL_BIT] == !$past(in_ready))
        else $error("status full bit wrong");
    a_status_phase: assert property ((rd && addr == OFF_STATUS)
        |=> rdata[ST_PH_LSB +: PH_LW] == $past(ph))
        else $error("status phase field wrong");
    a_ctrl_read: assert property ((rd && addr == OFF_CTRL)
        |=> rdata == DATA_W'($past(ctrl)))
        else $error("control read back wrong");
    a_rstval_read: assert property ((rd && addr == OFF_RSTVAL)
        |=> rdata == DATA_W'($past(rstval)))
        else $error("reset value read back wrong");

    c_full_stall: cover property (vld[LAST] && !in_ready && hit && ena_ok);
    c_clear_busy: cover property (clr && vld[0]);
    c_quarter: cover property (phase.len_m1 == 3'h3 && step && vld[0]);
    c_out_take: cover property (out_valid && out_ready);
    c_rstval_clear: cover property (clr && ctrl.use_rstval && vld[0]);

endmodule

`default_nettype wire

/* File: dv/pdl_sink.sv */
`default_nettype none

module pdl_sink (
    input  wire logic clk,       // system clock
    input  wire logic resetn,    // reset, active low
    input  wire logic slow,      // accept one word in four
    input  wire logic out_valid, // head offered
    output var  logic out_ready  // head accepted
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] cnt;

    // registered ready so the sink never reacts inside the offering cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt       <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            cnt       <= cnt + 2'h1;
            out_ready <= !slow || (cnt == 2'h3);
        end
    end
endmodule

`default_nettype wire

/* File: dv/tb_pdl_delay_line.sv */
`default_nettype none

module tb_pdl_delay_line;
    timeunit 1ns;
    timeprecision 1ps;
    import pdl_pkg::*;

    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    pdl_word_t         in_data = 16'h0;
    logic              in_valid = 1'b0;
    logic              in_ready;
    logic              ena = 1'b0;
    logic              sclr = 1'b0;
    pdl_word_t         out_data;
    logic              out_valid;
    logic              out_ready;
    logic              slow = 1'b0;
    logic              ena_used = 1'b0;
    logic              strict = 1'b1;
    logic              saw_full = 1'b0;
    logic [15:0]       seed = 16'h5cbc;
    logic [DATA_W-1:0] v;
    logic [16:0]       exp_q[$];
    pdl_word_t         got_q[$];
    int                err_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    int                n;

    pdl_delay_line pdl_delay_line_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .ena(ena), .sclr(sclr), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready));
    pdl_sink pdl_sink_i (.clk(clk), .resetn(resetn), .slow(slow), .out_valid(out_valid),
        .out_ready(out_ready));

    always #5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // index words make gaps visible; random words exercise every bit
    task automatic feed(input int cnt, input bit idx);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            in_valid <= 1'b1;
            in_data  <= idx ? pdl_word_t'(i) : seed;
            ena      <= seed[3];
        end
        @(posedge clk);
        in_valid <= 1'b0;
        // enable left high so words still in flight can drain
        ena      <= 1'b1;
    endtask

    task automatic drain(input string name);
        int q;
        int k;
        q = 0;
        k = 0;
        while (q < 8 && k < 400) begin
            @(posedge clk);
            #1 q = out_valid ? 0 : q + 1;
            k++;
        end
        k = 0;
        foreach (exp_q[i]) k += int'(exp_q[i][16]);
        cmp("words never delivered", 0, k);
        $display("test %s done", name);
    endtask

    // scoreboard: words offered on enabled cycles, in order; skipped ones must be optional
    always @(posedge clk) begin
        if (in_valid && (ena || !ena_used))
            exp_q.push_back({in_ready && strict, in_data});
        if (!in_ready)
            saw_full <= 1'b1;
        if (out_valid && out_ready) begin
            got_q.push_back(out_data);
            while (exp_q.size() > 0 && exp_q[0][15:0] !== out_data) begin
                if (exp_q[0][16])
                    cmp("word kept", 1, 0);
                void'(exp_q.pop_front());
            end
            cmp("out_data", exp_q.size() > 0 ? exp_q[0][15:0] : ~out_data, out_data);
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(OFF_CTRL, v);
        cmp("ctrl reset", 32'h2, v);
        rd_reg(OFF_PHASE, v);
        cmp("phase reset", 32'h1, v);
        rd_reg(4'h2, v);
        cmp("unmapped read", 32'h0, v);
        cmp("word width", INT_BITS + FRAC_BITS, $bits(out_data));
        @(posedge clk);
        in_valid <= 1'b1;
        in_data  <= 16'h8001;
        @(posedge clk);
        in_valid <= 1'b0;
        n = 0;
        while (!out_valid && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        cmp("latency", NSTAGES, n);
        drain("latency");
        feed(60, 0);
        drain("flow");
        slow = 1'b1;
        feed(80, 0);
        drain("stall");
        cmp("buffer filled", 1, saw_full);
        slow = 1'b0;
        wr_reg(OFF_CTRL, 32'h3);
        ena_used = 1'b1;
        feed(60, 0);
        drain("enable");
        ena_used = 1'b0;
        strict   = 1'b0;
        wr_reg(OFF_CTRL, 32'h2);
        for (int k = 0; k < 2; k++) begin
            wr_reg(OFF_PHASE, k ? 32'h304 : 32'h102);
            got_q.delete();
            feed(16, 1);
            drain("phase");
            cmp("phase count", k ? 4 : 8, got_q.size());
            for (int i = 1; i < got_q.size(); i++)
                cmp("phase step", k ? 4 : 2, got_q[i] - got_q[i-1]);
        end
        wr_reg(OFF_PHASE, 32'h1);
        strict   = 1'b1;
        ena_used = 1'b1;
        slow     = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr_reg(OFF_CTRL, k ? 32'h7 : 32'h3);
            wr_reg(OFF_RSTVAL, 32'ha5c3);
            feed(12, 0);
            @(posedge clk);
            sclr <= 1'b1;
            // enable high, so the clear has to win against it
            ena  <= 1'b1;
            @(posedge clk);
            sclr <= 1'b0;
            #1 exp_q.delete();
            cmp("clear valid", 0, out_valid);
            cmp("clear value", k ? 32'ha5c3 : 32'h0, out_data);
            cmp("clear ready", 1, in_ready);
            rd_reg(OFF_STATUS, v);
            cmp("sign bit", k ? 1 : 0, v[ST_SIGN_BIT]);
            feed(12, 0);
            drain("clear");
        end
        // clear not in use: an sclr pulse must cost no word
        wr_reg(OFF_CTRL, 32'h1);
        feed(12, 0);
        @(posedge clk);
        sclr <= 1'b1;
        @(posedge clk);
        sclr <= 1'b0;
        drain("clear off");
        final_report();
    end
endmodule

`default_nettype wire
